// *** src/sdram_cmd_pkg.sv ***
// shared constants and types for the sdram command link
package sdram_cmd_pkg;
   localparam int DQ_W      = 16;
   localparam int BANKS     = 8;
   localparam int BA_W      = 3;
   localparam int ADDR_W    = 14;
   localparam int COL_W     = 10;
   localparam int A10_POS   = 10;
   localparam int A12_POS   = 12;
   localparam int BEATS_BL8 = 8;
   localparam int BEATS_BC4 = 4;
   localparam int MR_COUNT  = 4;
   localparam int CLK_DIV   = 3;  // host clock cycles per link clock half period
   // mode register fields used by this decoder
   localparam int MR0_BL_LSB   = 0;  // 2-bit burst length field
   localparam int MR1_RTT_LSB  = 2;  // nominal termination bit
   localparam int MR2_RTT_LSB  = 9;  // dynamic termination field, 2 bits
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;

   // decoded command codes, numbered in sequence, not the {ras, cas, we} pin levels
   typedef enum logic [3:0] {
      CMD_DESELECT = 4'h0,
      CMD_NOP      = 4'h1,
      CMD_ACTIVATE = 4'h2,
      CMD_PRECHG   = 4'h3,
      CMD_READ     = 4'h4,
      CMD_WRITE    = 4'h5,
      CMD_MRS      = 4'h6,
      CMD_REFRESH  = 4'h7,
      CMD_ZQ       = 4'h8,
      CMD_ILLEGAL  = 4'h9
   } cmd_t;

   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_DOWN   = 2'b01,
      PWR_SELF   = 2'b11
   } pwr_t;
endpackage

// *** src/sdram_link_if.sv ***
// link pins between memory controller and sdram device
`timescale 1ns/10ps
interface sdram_link_if;
   logic        ck;
   logic        cke;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [2:0]  ba;
   logic [13:0] addr;
   logic        odt;
   logic        reset_n;
   logic [1:0]  dm;
   logic [15:0] dq_h;
   logic        dq_h_oe;
   logic [15:0] dq_d;
   logic        dq_d_oe;
   logic        dqs_h;
   logic        dqs_h_oe;
   logic        dqs_d;
   logic        dqs_d_oe;
   logic        term_on;
   // resolved wire levels, the driving end wins
   logic [15:0] dq;
   logic        dqs;
   assign dq  = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 16'h0000);
   assign dqs = dqs_d_oe ? dqs_d : (dqs_h_oe ? dqs_h : 1'b0);

   modport host (
      output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, reset_n, dm,
      output dq_h, dq_h_oe, dqs_h, dqs_h_oe,
      input  dq, dqs
   );
   modport device (
      input  ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, reset_n, dm,
      output dq_d, dq_d_oe, dqs_d, dqs_d_oe, term_on,
      input  dq, dqs
   );
endinterface

// *** src/cmd_decode.sv ***
// combinational command decoder from strobe levels
`timescale 1ns/10ps
module cmd_decode (
   // command pins
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   // decoded command
   output sdram_cmd_pkg::cmd_t cmd
);
   // select high masks everything else
   always_comb begin
      if (cs_n) begin
         cmd = sdram_cmd_pkg::CMD_DESELECT;
      end else begin
         case ({ras_n, cas_n, we_n})
            3'b111: cmd = sdram_cmd_pkg::CMD_NOP;
            3'b011: cmd = sdram_cmd_pkg::CMD_ACTIVATE;
            3'b010: cmd = sdram_cmd_pkg::CMD_PRECHG;
            3'b101: cmd = sdram_cmd_pkg::CMD_READ;
            3'b100: cmd = sdram_cmd_pkg::CMD_WRITE;
            3'b000: cmd = sdram_cmd_pkg::CMD_MRS;
            3'b001: cmd = sdram_cmd_pkg::CMD_REFRESH;
            3'b110: cmd = sdram_cmd_pkg::CMD_ZQ;
            default: cmd = sdram_cmd_pkg::CMD_ILLEGAL;
         endcase
      end
   end
endmodule // cmd_decode

// *** src/sdram_device.sv ***
// sdram device end: command decode, bank state, burst data path
`timescale 1ns/10ps

// Functional notes
// - data moves on both strobe edges
// - high mask blocks its byte, independently
// - registered termination input enables termination
// - termination ignored when both registers disable
// - asynchronous active low reset holds device
// - commands need previous and current enable high
// - activate opens row in chosen bank
// - write decode; A12 picks chop or eight
// - read decode; A12 picks chop or eight
// - A10 high means auto precharge after burst
// - column starts burst; A12 only if enabled
// - mode set loads selected register while idle
// - power-down entry and exit on enable edges
// - controller activates idle, accesses active banks
// - eight banks, eight-beat prefetch word
// - bursts of eight or chopped four, ordered
// - one data word every clock
// - controller initializes before normal access
// - precharge closes the selected bank
module sdram_device (
   // link side
   sdram_link_if.device                     link,
   // user side, core clock domain
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   output logic [sdram_cmd_pkg::BANKS-1:0]  bank_open,
   output logic                             self_refresh,
   output logic                             zq_long_seen
);
   localparam int DQ_W = sdram_cmd_pkg::DQ_W;
   localparam int BW   = sdram_cmd_pkg::BA_W;
   localparam int AW   = sdram_cmd_pkg::ADDR_W;
   localparam int CW   = sdram_cmd_pkg::COL_W;

   // link-domain state
   logic                  cke_prev_reg;
   sdram_cmd_pkg::cmd_t   cmd;
   sdram_cmd_pkg::pwr_t   pwr_reg;
   logic [AW-1:0]         mr_reg [sdram_cmd_pkg::MR_COUNT];
   logic [AW-1:0]         row_reg [sdram_cmd_pkg::BANKS];
   logic [sdram_cmd_pkg::BANKS-1:0] open_reg;
   logic [DQ_W-1:0]       mem_reg [sdram_cmd_pkg::BANKS*(1<<CW)];
   logic                  rd_reg;
   logic                  wr_reg;
   logic                  ap_reg;
   logic [BW-1:0]         bank_reg;
   logic [CW-1:0]         col_reg;
   logic [3:0]            beats_reg;
   logic [3:0]            beat_reg;
   logic                  odt_reg;
   logic                  zql_reg;
   logic                  cmd_ok;
   logic                  chop;
   logic [CW-1:0]         beat_col;
   logic [BW+CW-1:0]      mem_idx;

   cmd_decode u_dec (
      .cs_n  (link.cs_n),
      .ras_n (link.ras_n),
      .cas_n (link.cas_n),
      .we_n  (link.we_n),
      .cmd   (cmd)
   );

   // both enable samples high, not in a low-power state
   assign cmd_ok = cke_prev_reg && link.cke && (pwr_reg == sdram_cmd_pkg::PWR_ACTIVE);

   // chop only honored when the mode register allows on-the-fly choice
   always_comb begin
      case (mr_reg[0][sdram_cmd_pkg::MR0_BL_LSB +: 2])
         sdram_cmd_pkg::BL_OTF:    chop = !link.addr[sdram_cmd_pkg::A12_POS];
         sdram_cmd_pkg::BL_FIXED4: chop = 1'b1;
         default:                  chop = 1'b0;
      endcase
   end

   // sequential order within the burst, wrapping at the eight-column boundary
   assign beat_col = {col_reg[CW-1:3], col_reg[2:0] + beat_reg[2:0]};
   assign mem_idx  = {bank_reg, beat_col};

   // enable history
   always_ff @(posedge link.ck or negedge link.reset_n) begin
      if (!link.reset_n) begin
         cke_prev_reg <= 1'b0;
      end else begin
         cke_prev_reg <= link.cke;
      end
   end

   // power state
   always_ff @(posedge link.ck or negedge link.reset_n) begin
      if (!link.reset_n) begin
         pwr_reg <= sdram_cmd_pkg::PWR_ACTIVE;
      end else begin
         case (pwr_reg)
            sdram_cmd_pkg::PWR_ACTIVE: begin
               if (cke_prev_reg && !link.cke) begin
                  if (cmd == sdram_cmd_pkg::CMD_REFRESH && open_reg == '0) begin
                     pwr_reg <= sdram_cmd_pkg::PWR_SELF;
                  end else if (cmd == sdram_cmd_pkg::CMD_DESELECT ||
                               cmd == sdram_cmd_pkg::CMD_NOP) begin
                     pwr_reg <= sdram_cmd_pkg::PWR_DOWN;
                  end
               end
            end
            sdram_cmd_pkg::PWR_DOWN, sdram_cmd_pkg::PWR_SELF: begin
               if (!cke_prev_reg && link.cke &&
                   (cmd == sdram_cmd_pkg::CMD_DESELECT || cmd == sdram_cmd_pkg::CMD_NOP)) begin
                  pwr_reg <= sdram_cmd_pkg::PWR_ACTIVE;
               end
            end
            default: pwr_reg <= sdram_cmd_pkg::PWR_ACTIVE;
         endcase
      end
   end

   // mode registers, only written while all banks idle
   always_ff @(posedge link.ck or negedge link.reset_n) begin
      if (!link.reset_n) begin
         for (int i = 0; i < sdram_cmd_pkg::MR_COUNT; i++) begin
            mr_reg[i] <= sdram_cmd_pkg::MR_RESET;
         end
      end else if (cmd_ok && cmd == sdram_cmd_pkg::CMD_MRS && open_reg == '0
                   && !link.ba[2]) begin
         mr_reg[link.ba[1:0]] <= link.addr;
      end
   end

   // bank open state and rows; eight independent banks
   always_ff @(posedge link.ck or negedge link.reset_n) begin
      if (!link.reset_n) begin
         open_reg <= '0;
         for (int i = 0; i < sdram_cmd_pkg::BANKS; i++) begin
            row_reg[i] <= '0;
         end
      end else begin
         if (cmd_ok && cmd == sdram_cmd_pkg::CMD_ACTIVATE) begin
            open_reg[link.ba] <= 1'b1;
            row_reg[link.ba]  <= link.addr;
         end else if (cmd_ok && cmd == sdram_cmd_pkg::CMD_PRECHG) begin
            if (link.addr[sdram_cmd_pkg::A10_POS]) begin
               open_reg <= '0;
            end else begin
               open_reg[link.ba] <= 1'b0;
            end
         end
         // auto precharge at the last beat
         if ((rd_reg || wr_reg) && ap_reg && beat_reg == beats_reg - 4'd1) begin
            open_reg[bank_reg] <= 1'b0;
         end
      end
   end

   // burst launch and beat counter; reads and writes to a closed bank are ignored
   always_ff @(posedge link.ck or negedge link.reset_n) begin
      if (!link.reset_n) begin
         rd_reg    <= 1'b0;
         wr_reg    <= 1'b0;
         ap_reg    <= 1'b0;
         bank_reg  <= '0;
         col_reg   <= '0;
         beats_reg <= 4'd0;
         beat_reg  <= 4'd0;
      end else if (cmd_ok && (cmd == sdram_cmd_pkg::CMD_READ ||
                              cmd == sdram_cmd_pkg::CMD_WRITE)
                   && open_reg[link.ba]) begin
         rd_reg    <= (cmd == sdram_cmd_pkg::CMD_READ);
         wr_reg    <= (cmd == sdram_cmd_pkg::CMD_WRITE);
         ap_reg    <= link.addr[sdram_cmd_pkg::A10_POS];
         bank_reg  <= link.ba;
         col_reg   <= link.addr[CW-1:0];
         beats_reg <= chop ? 4'(sdram_cmd_pkg::BEATS_BC4)
                           : 4'(sdram_cmd_pkg::BEATS_BL8);
         beat_reg  <= 4'd0;
      end else if ((rd_reg || wr_reg) && beat_reg == beats_reg - 4'd1) begin
         rd_reg   <= 1'b0;
         wr_reg   <= 1'b0;
         beat_reg <= 4'd0;
      end else if (rd_reg || wr_reg) begin
         beat_reg <= beat_reg + 4'd1;
      end
   end

   // array: one beat per cycle here; pins carry a beat per strobe edge
   always_ff @(posedge link.ck) begin
      if (wr_reg) begin
         if (!link.dm[0]) begin
            mem_reg[mem_idx][7:0]  <= link.dq[7:0];
         end
         if (!link.dm[1]) begin
            mem_reg[mem_idx][15:8] <= link.dq[15:8];
         end
      end
   end

   // read data and strobe out; strobe toggles each beat so both edges carry data
   always_ff @(posedge link.ck or negedge link.reset_n) begin
      if (!link.reset_n) begin
         link.dq_d    <= '0;
         link.dq_d_oe <= 1'b0;
         link.dqs_d   <= 1'b0;
         link.dqs_d_oe <= 1'b0;
      end else begin
         link.dq_d_oe  <= rd_reg;
         link.dqs_d_oe <= rd_reg;
         link.dq_d     <= rd_reg ? mem_reg[mem_idx] : '0;
         link.dqs_d    <= rd_reg ? beat_reg[0] : 1'b0;
      end
   end

   // termination: registered input, ignored when both registers disable it
   always_ff @(posedge link.ck or negedge link.reset_n) begin
      if (!link.reset_n) begin
         odt_reg <= 1'b0;
      end else begin
         odt_reg <= link.odt && link.cke;
      end
   end
   assign link.term_on = odt_reg &&
      (mr_reg[1][sdram_cmd_pkg::MR1_RTT_LSB] ||
       mr_reg[2][sdram_cmd_pkg::MR2_RTT_LSB +: 2] != 2'b00);

   // calibration kind flag
   always_ff @(posedge link.ck or negedge link.reset_n) begin
      if (!link.reset_n) begin
         zql_reg <= 1'b0;
      end else if (cmd_ok && cmd == sdram_cmd_pkg::CMD_ZQ && open_reg == '0) begin
         zql_reg <= link.addr[sdram_cmd_pkg::A10_POS];
      end
   end

   // status levels into the core domain through two flops
   logic [sdram_cmd_pkg::BANKS+1:0] sync1_reg;
   logic [sdram_cmd_pkg::BANKS+1:0] sync2_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {zql_reg, pwr_reg == sdram_cmd_pkg::PWR_SELF, open_reg};
         sync2_reg <= sync1_reg;
      end
   end
   assign bank_open    = sync2_reg[sdram_cmd_pkg::BANKS-1:0];
   assign self_refresh = sync2_reg[sdram_cmd_pkg::BANKS];
   assign zq_long_seen = sync2_reg[sdram_cmd_pkg::BANKS+1];
endmodule // sdram_device

// *** src/sdram_host.sv ***
// controller end: divides its clock into the link clock, drives commands
`timescale 1ns/10ps
module sdram_host (
   // link side
   sdram_link_if.host   link,
   // user side
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [3:0]  req_cmd,
   input  wire logic        req_cke,
   input  wire logic [2:0]  req_ba,
   input  wire logic [13:0] req_addr,
   input  wire logic        req_odt,
   input  wire logic [1:0]  req_dm,
   input  wire logic [15:0] req_wdata,
   input  wire logic        req_wdata_en,
   output logic [15:0]      rd_data
);
   logic [1:0]  div_reg;
   logic        ck_reg;
   logic        rise;
   logic [15:0] dq_s1_reg;
   logic [15:0] dq_s2_reg;

   // link clock from divider; commands change on falling edge, centered for device
   assign rise      = (div_reg == 2'(sdram_cmd_pkg::CLK_DIV - 1)) && ck_reg;
   assign req_ready = rise;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_reg <= 2'd0;
         ck_reg  <= 1'b0;
      end else if (div_reg == 2'(sdram_cmd_pkg::CLK_DIV - 1)) begin
         div_reg <= 2'd0;
         ck_reg  <= !ck_reg;
      end else begin
         div_reg <= div_reg + 2'd1;
      end
   end
   assign link.ck      = ck_reg;
   assign link.reset_n = reset_n;

   // command pins; idle deselect with enable low until user raises it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         link.cke   <= 1'b0;
         link.cs_n  <= 1'b1;
         link.ras_n <= 1'b1;
         link.cas_n <= 1'b1;
         link.we_n  <= 1'b1;
         link.ba    <= '0;
         link.addr  <= '0;
         link.odt   <= 1'b0;
         link.dm    <= 2'b00;
         link.dq_h  <= '0;
         link.dq_h_oe  <= 1'b0;
         link.dqs_h    <= 1'b0;
         link.dqs_h_oe <= 1'b0;
      end else if (rise) begin
         link.cke  <= req_cke;
         link.ba   <= req_ba;
         link.addr <= req_addr;
         link.odt  <= req_odt;
         link.dm   <= req_dm;
         link.dq_h <= req_wdata;
         link.dq_h_oe  <= req_wdata_en;
         link.dqs_h_oe <= req_wdata_en;
         link.dqs_h    <= req_wdata_en ? !link.dqs_h : 1'b0;
         if (req_valid) begin
            case (sdram_cmd_pkg::cmd_t'(req_cmd))
               sdram_cmd_pkg::CMD_ACTIVATE: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h3;
               sdram_cmd_pkg::CMD_PRECHG:   {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h2;
               sdram_cmd_pkg::CMD_READ:     {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h5;
               sdram_cmd_pkg::CMD_WRITE:    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h4;
               sdram_cmd_pkg::CMD_MRS:      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h0;
               sdram_cmd_pkg::CMD_REFRESH:  {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h1;
               sdram_cmd_pkg::CMD_ZQ:       {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h6;
               sdram_cmd_pkg::CMD_NOP:      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h7;
               default:                     {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
            endcase
         end else begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
         end
      end
   end

   // read data from the other domain, three flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dq_s1_reg <= '0;
         dq_s2_reg <= '0;
         rd_data   <= '0;
      end else begin
         dq_s1_reg <= link.dq;
         dq_s2_reg <= dq_s1_reg;
         rd_data   <= dq_s2_reg;
      end
   end
endmodule // sdram_host

// *** sim/sdram_link_checker.sv ***
// link-level assertions between controller and device ends
`timescale 1ns/10ps
module sdram_link_checker (
   // link clock and reset
   input wire logic        ck,
   input wire logic        reset_n,
   // command pins
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [2:0]  ba,
   input wire logic [13:0] addr,
   input wire logic        odt,
   // data side
   input wire logic        dq_h_oe,
   input wire logic        dq_d_oe,
   input wire logic        dqs_d,
   input wire logic        term_on
);
   logic       cke_reg;
   logic [7:0] open_reg;
   logic [1:0] rtt_reg;
   logic       go;
   logic [2:0] op;
   logic       rd_any;
   logic       rd_ok;
   logic       wr_any;
   logic       fresh_reg;

   // a command counts only with both enable samples high
   assign go     = cke && cke_reg && !cs_n;
   assign op     = {ras_n, cas_n, we_n};
   assign rd_any = go && op == 3'h5;
   assign rd_ok  = rd_any && open_reg[ba];
   assign wr_any = go && op == 3'h4;

   // enable history and termination setting from mode register writes
   always_ff @(posedge ck or negedge reset_n) begin
      if (!reset_n) begin
         cke_reg <= 1'b0;
         rtt_reg <= 2'h0;
         fresh_reg <= 1'b1;
      end else begin
         cke_reg <= cke;
         fresh_reg <= 1'b0;
         if (go && op == 3'h0 && open_reg == 8'h00 && ba == 3'h1) begin
            rtt_reg[0] <= addr[2];
         end
         if (go && op == 3'h0 && open_reg == 8'h00 && ba == 3'h2) begin
            rtt_reg[1] <= |addr[10:9];
         end
      end
   end

   // bank state; auto precharge closes early, which only weakens checks
   always_ff @(posedge ck or negedge reset_n) begin
      if (!reset_n) begin
         open_reg <= 8'h00;
      end else if (go && op == 3'h3) begin
         open_reg[ba] <= 1'b1;
      end else if (go && op == 3'h2) begin
         open_reg <= addr[10] ? 8'h00 : open_reg & ~(8'h01 << ba);
      end else if ((rd_any || wr_any) && addr[10]) begin
         open_reg[ba] <= 1'b0;
      end
   end

   default clocking cb @(posedge ck); endclocking
   default disable iff (!reset_n);

   sequence s_burst4;
      dq_d_oe [*4];
   endsequence
   sequence s_no_read8;
      !rd_any [*8];
   endsequence

   chk_read_burst: assert property (rd_ok |-> ##[1:2] s_burst4)
      else $error("read burst too short");
   chk_oe_cause: assert property ($rose(dq_d_oe) |-> $past(rd_ok) || $past(rd_ok, 2))
      else $error("device drove data without an accepted read");
   chk_burst_end: assert property (rd_any ##1 s_no_read8 |-> ##[0:2] !dq_d_oe)
      else $error("read burst ran past eight beats");
   chk_strobe_toggle: assert property (dq_d_oe && $past(dq_d_oe) |-> dqs_d != $past(dqs_d))
      else $error("strobe did not mark a beat");
   chk_host_data: assert property ($rose(dq_h_oe) |-> $past(wr_any) || $past(wr_any, 2))
      else $error("host drove data without a write");
   chk_term_off: assert property ((!odt) [*3] |-> !term_on)
      else $error("termination on with control low");
   chk_term_cause: assert property ($rose(term_on) |-> (|rtt_reg) && ($past(odt) || $past(odt, 2)))
      else $error("termination on while disabled or unrequested");
   chk_reset_pins: assert property (fresh_reg |-> !cke && cs_n && !dq_d_oe && !term_on)
      else $error("pins active during reset");
endmodule // sdram_link_checker

// *** sim/tb.sv ***
// bench joining controller and device across the link
`timescale 1ns/10ps
module tb;
   typedef struct {
      sdram_cmd_pkg::cmd_t c;
      logic [2:0]          b;
      logic [13:0]         a;
      logic [1:0]          s;
      logic [7:0]          e;
   } row_t;
   logic        clk;
   logic        reset_n;
   logic        req_valid;
   logic        req_ready;
   logic [3:0]  req_cmd;
   logic        req_cke;
   logic [2:0]  req_ba;
   logic [13:0] req_addr;
   logic        req_odt;
   logic [1:0]  req_dm;
   logic [15:0] req_wdata;
   logic        req_wdata_en;
   logic [15:0] rd_data;
   logic [7:0]  bank_open;
   logic        self_refresh;
   logic        zq_long_seen;
   logic [15:0] mem [8];
   int          miscompares;
   int          num_checks;
   // command, bank, address, flag selector, expected flag value
   row_t rows [8] = '{
      '{sdram_cmd_pkg::CMD_ACTIVATE, 3'h1, 14'h0000, 2'h0, 8'h02},
      '{sdram_cmd_pkg::CMD_ACTIVATE, 3'h5, 14'h0000, 2'h0, 8'h22},
      '{sdram_cmd_pkg::CMD_PRECHG, 3'h1, 14'h0000, 2'h0, 8'h20},
      '{sdram_cmd_pkg::CMD_ACTIVATE, 3'h2, 14'h0000, 2'h0, 8'h24},
      '{sdram_cmd_pkg::CMD_NOP, 3'h7, 14'h0400, 2'h0, 8'h24},
      '{sdram_cmd_pkg::CMD_PRECHG, 3'h0, 14'h0400, 2'h0, 8'h00},
      '{sdram_cmd_pkg::CMD_ZQ, 3'h0, 14'h0000, 2'h1, 8'h00},
      '{sdram_cmd_pkg::CMD_ZQ, 3'h0, 14'h0400, 2'h1, 8'h01}};

   sdram_link_if lnk ();
   sdram_host i_sdram_host (.link(lnk), .clk(clk), .reset_n(reset_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_cmd(req_cmd), .req_cke(req_cke), .req_ba(req_ba),
      .req_addr(req_addr), .req_odt(req_odt), .req_dm(req_dm), .req_wdata(req_wdata),
      .req_wdata_en(req_wdata_en), .rd_data(rd_data));
   sdram_device i_sdram_device (.link(lnk), .clk(clk), .reset_n(reset_n),
      .bank_open(bank_open), .self_refresh(self_refresh), .zq_long_seen(zq_long_seen));
   sdram_link_checker i_sdram_link_checker (.ck(lnk.ck), .reset_n(lnk.reset_n), .cke(lnk.cke),
      .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba),
      .addr(lnk.addr), .odt(lnk.odt), .dq_h_oe(lnk.dq_h_oe), .dq_d_oe(lnk.dq_d_oe),
      .dqs_d(lnk.dqs_d), .term_on(lnk.term_on));

   // 200 MHz core clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // one request, held until the edge after ready is seen settled
   task automatic issue(input sdram_cmd_pkg::cmd_t c, input logic [2:0] b = 3'h0,
         input logic [13:0] a = 14'h0000, input logic ke = 1'b1, input logic o = 1'b0,
         input logic [1:0] m = 2'h0, input logic [15:0] d = 16'h0000, input logic de = 1'b0);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_ba <= b;
      req_addr <= a;
      req_cke <= ke;
      req_odt <= o;
      req_dm <= m;
      req_wdata <= d;
      req_wdata_en <= de;
      for (n = 0; n < 100; n++) begin
         @(negedge clk);
         if (req_ready === 1'b1) break;
      end
      check(n < 100, "request not taken");
      if (n == 100) conclude();
      @(posedge clk);
      req_valid <= 1'b0;
   endtask

   function automatic logic [7:0] probe(input logic [1:0] s);
      case (s)
         2'h0: return bank_open;
         2'h1: return {7'h00, zq_long_seen};
         2'h2: return {7'h00, self_refresh};
         default: return {7'h00, lnk.term_on};
      endcase
   endfunction

   task automatic wait_for(input logic [1:0] s, input logic [7:0] e);
      int n;
      for (n = 0; n < 80; n++) begin
         @(negedge clk);
         if (probe(s) === e) break;
      end
      check(probe(s) === e, "state flag wrong");
      if (n == 80) conclude();
   endtask

   // eight write beats into bank 3; masked bytes keep the model value
   task automatic wr(input logic [9:0] col, input logic mask);
      int k;
      logic [15:0] d;
      logic [1:0] m;
      logic [2:0] c;
      issue(sdram_cmd_pkg::CMD_WRITE, 3'h3, {4'h0, col});
      for (k = 0; k < 8; k++) begin
         d = {4'ha, 4'(k), mask ? 4'h5 : 4'h9, 4'(k + 3)};
         m = mask ? 2'(k) : 2'h0;
         c = 3'(col + 10'(k));
         if (!m[0]) mem[c][7:0] = d[7:0];
         if (!m[1]) mem[c][15:8] = d[15:8];
         issue(sdram_cmd_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b0, m, d, 1'b1);
      end
   endtask

   // read bank 3, compare the beats seen on the wire in wrapping order
   task automatic rd(input logic [9:0] col, input logic a12, input logic a10,
         input logic ke, input int n);
      int i;
      int cnt;
      cnt = 0;
      issue(sdram_cmd_pkg::CMD_READ, 3'h3, {1'b0, a12, 1'b0, a10, col}, ke);
      for (i = 0; i < 24; i++) begin
         @(negedge lnk.ck);
         @(negedge clk);
         if (lnk.dq_d_oe === 1'b1) begin
            check(lnk.dq === mem[3'(col + 10'(cnt))] && rd_data === lnk.dq,
               "read beat data");
            cnt++;
         end
      end
      check(cnt == n, "read beat count");
   endtask

   initial begin
      miscompares = 0;
      num_checks = 0;
      reset_n = 1'b1;
      req_valid = 1'b0;
      req_cmd = 4'h0;
      req_cke = 1'b0;
      req_ba = 3'h0;
      req_addr = 14'h0000;
      req_odt = 1'b0;
      req_dm = 2'h0;
      req_wdata = 16'h0000;
      req_wdata_en = 1'b0;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      issue(sdram_cmd_pkg::CMD_NOP);
      foreach (rows[i]) begin
         issue(rows[i].c, rows[i].b, rows[i].a);
         wait_for(rows[i].s, rows[i].e);
      end
      $display("test command table done");
      // termination request is ignored until a mode register enables it
      repeat (3) issue(sdram_cmd_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b1);
      check(lnk.term_on === 1'b0, "termination while disabled");
      issue(sdram_cmd_pkg::CMD_MRS, 3'h1, 14'h0004);
      issue(sdram_cmd_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b1);
      wait_for(2'h3, 8'h01);
      issue(sdram_cmd_pkg::CMD_NOP);
      wait_for(2'h3, 8'h00);
      $display("test termination done");
      // fixed eight-beat bursts, second write byte-masked
      issue(sdram_cmd_pkg::CMD_ACTIVATE, 3'h3);
      wr(10'h000, 1'b0);
      wr(10'h004, 1'b1);
      rd(10'h003, 1'b0, 1'b0, 1'b1, 8);
      $display("test masked burst done");
      // on-the-fly chop, then auto precharge closes the bank
      issue(sdram_cmd_pkg::CMD_PRECHG, 3'h0, 14'h0400);
      issue(sdram_cmd_pkg::CMD_MRS, 3'h0, 14'h0001);
      issue(sdram_cmd_pkg::CMD_ACTIVATE, 3'h3);
      rd(10'h006, 1'b0, 1'b0, 1'b1, 4);
      rd(10'h001, 1'b1, 1'b1, 1'b1, 8);
      wait_for(2'h0, 8'h00);
      $display("test chop and auto precharge done");
      // read refused in power-down, accepted after exit
      issue(sdram_cmd_pkg::CMD_ACTIVATE, 3'h3);
      issue(sdram_cmd_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b0);
      rd(10'h000, 1'b1, 1'b0, 1'b0, 0);
      issue(sdram_cmd_pkg::CMD_NOP);
      rd(10'h000, 1'b1, 1'b0, 1'b1, 8);
      $display("test power-down done");
      issue(sdram_cmd_pkg::CMD_PRECHG, 3'h0, 14'h0400);
      issue(sdram_cmd_pkg::CMD_REFRESH, 3'h0, 14'h0000, 1'b0);
      wait_for(2'h2, 8'h01);
      issue(sdram_cmd_pkg::CMD_NOP);
      wait_for(2'h2, 8'h00);
      $display("test self refresh done");
      // reset in mid-run with a bank open
      issue(sdram_cmd_pkg::CMD_ACTIVATE, 3'h6);
      wait_for(2'h0, 8'h40);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      check(bank_open === 8'h00 && lnk.cke === 1'b0 && lnk.cs_n === 1'b1, "reset state");
      reset_n <= 1'b1;
      issue(sdram_cmd_pkg::CMD_NOP);
      issue(sdram_cmd_pkg::CMD_ACTIVATE, 3'h6);
      wait_for(2'h0, 8'h40);
      $display("test reset done");
      conclude();
   end
endmodule // tb
